// ### rtl/ledl_pkg.sv
package ledl_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_LED  = 8;
	localparam int NUM_TRIG = 5;
	localparam int POOL_W   = 32;
	localparam int SEL_W    = 5;
	localparam int COL_W    = 3;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] STATE_OFS     = 12'h004;
	localparam logic [11:0] CFG_BASE_OFS  = 12'h010;
	localparam logic [11:0] CFG_STRIDE    = 12'h008;
	localparam logic [11:0] CFG_B_OFS     = 12'h004;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CFGA_INV_LSB   = 25;
	localparam int CFGB_LATCH_BIT = 0;
	localparam int CFGB_ACK_LSB   = 1;
	localparam int CFGB_ON_LSB    = 8;
	localparam int CFGB_OFF_LSB   = 12;
	localparam int STATE_COMB_LSB = 8;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] CFGA_RST = 32'h0000_0000;
	localparam logic [31:0] CFGB_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		COL_OFF     = 3'b000,
		COL_GREEN   = 3'b001,
		COL_RED     = 3'b010,
		COL_RED_FL  = 3'b011,
		COL_GREEN_FL = 3'b100
	} ledl_colour_t;

	typedef struct packed {
		logic [NUM_TRIG-1:0][SEL_W-1:0] trig_sel;
		logic [NUM_TRIG-1:0]            trig_inv;
		logic                           latch_en;
		logic [SEL_W-1:0]               ack_sel;
		logic [COL_W-1:0]               on_state_colour;
		logic [COL_W-1:0]               off_state_colour;
	} ledl_cfg_t;

	typedef struct packed {
		logic green;
		logic red;
	} ledl_drive_t;

endpackage

// ### rtl/ledl_cell.sv
`timescale 1ns/1ps
module ledl_cell (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         warm_restart,
	input  wire ledl_pkg::ledl_cfg_t          cfg,
	input  wire logic [ledl_pkg::POOL_W-1:0]  status_pool,
	input  wire logic                         global_hold_clear,
	input  wire logic                         blink_phase,
	output      logic                         comb_state,
	output      logic                         held,
	output      ledl_pkg::ledl_drive_t        drive
);
	import ledl_pkg::*;

	logic next_comb;
	logic all_unassigned;
	logic ack_hit;
	logic release_ok;
	logic shown;
	logic [COL_W-1:0] col;

	// ************************************************************
	// Trigger combination
	// ************************************************************
	always_comb begin
		next_comb = 1'b0;
		all_unassigned = 1'b1;
		for (int k = 0; k < NUM_TRIG; k++) begin
			if (cfg.trig_sel[k] != '0) begin
				all_unassigned = 1'b0;
				next_comb = next_comb | (status_pool[cfg.trig_sel[k]] ^ cfg.trig_inv[k]);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comb_state <= 1'b0;
		end else if (warm_restart) begin
			comb_state <= 1'b0;
		end else begin
			comb_state <= next_comb;
		end
	end

	// ************************************************************
	// Latch
	// ************************************************************
	// The ack source is only honoured while latching is on.
	assign ack_hit = cfg.latch_en && (cfg.ack_sel != '0) && status_pool[cfg.ack_sel];
	// The incoming trigger state must be idle as well as the registered one.
	// A restart blanks the registered state while the triggers may still be active.
	assign release_ok = !comb_state && !next_comb
		&& (ack_hit || global_hold_clear || !cfg.latch_en || all_unassigned);

	// A warm restart leaves the held state alone so the panel comes back as it was.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held <= 1'b0;
		end else if (cfg.latch_en && comb_state) begin
			held <= 1'b1;
		end else if (release_ok) begin
			held <= 1'b0;
		end
	end

	assign shown = cfg.latch_en ? (comb_state | held) : comb_state;

	// ************************************************************
	// Colour
	// ************************************************************
	assign col = shown ? cfg.on_state_colour : cfg.off_state_colour;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive <= '0;
		end else if (warm_restart) begin
			drive <= '0;
		end else begin
			unique case (col)
				COL_OFF:      drive <= '{green: 1'b0, red: 1'b0};
				COL_GREEN:    drive <= '{green: 1'b1, red: 1'b0};
				COL_RED:      drive <= '{green: 1'b0, red: 1'b1};
				COL_RED_FL:   drive <= '{green: 1'b0, red: blink_phase};
				COL_GREEN_FL: drive <= '{green: blink_phase, red: 1'b0};
				default:      drive <= '{green: 1'b0, red: 1'b0};
			endcase
		end
	end

endmodule // ledl_cell

// ### rtl/ledl_top.sv
// Contract
// - Each indicator takes up to five trigger selects from the status pool, zero meaning none.
// - Each trigger has its own invert bit that complements it before use.
// - An unassigned trigger contributes 0 whatever its invert bit says.
// - With latching on, an active combined state is held after the triggers drop.
// - With latching off, the indicator follows the combined state with no memory.
// - The ack source works only with latching on and clears the hold only with triggers idle.
// - With any trigger active the indicator shows its on-state colour.
// - With no trigger active and nothing held it shows its off-state colour from the same choices.
// - A colour code is unlit, green, red, red flashing or green flashing.
// - The system-health indicator is fixed and bypasses the configurable logic.
// - A warm restart keeps every held state.
// - Turning latching off or unassigning all triggers releases a hold once triggers are idle.
// - A global clear releases each hold whose triggers are idle while the clear is applied.
`timescale 1ns/1ps
module ledl_top (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [11:0]                         paddr,
	input  wire logic [31:0]                         pwdata,
	input  wire logic [3:0]                          pstrb,
	output      logic [31:0]                         prdata,
	output      logic                                pready,
	output      logic                                pslverr,
	input  wire logic [ledl_pkg::POOL_W-1:0]         status_pool,
	input  wire logic                                global_hold_clear,
	input  wire logic                                blink_en,
	input  wire logic                                warm_restart,
	input  wire logic                                sys_ok,
	output      logic                                sys_ok_green,
	output      ledl_pkg::ledl_drive_t [ledl_pkg::NUM_LED-1:0] led_drive
);
	import ledl_pkg::*;

	logic [NUM_LED-1:0][31:0] cfg_a;
	logic [NUM_LED-1:0][31:0] cfg_b;
	ledl_cfg_t [NUM_LED-1:0]  cfg;
	logic [NUM_LED-1:0]       comb_state;
	logic [NUM_LED-1:0]       held;
	logic                     sw_clear;
	logic                     blink_phase;
	logic                     wr_en;
	logic                     rd_en;
	logic                     hit;
	logic [31:0]              rd_word;
	logic [31:0]              wmask;

	// ************************************************************
	// APB access decode
	// ************************************************************
	// Zero wait states: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{pstrb[b]}};
		end
	end

	always_comb begin
		hit = 1'b0;
		rd_word = 32'h0000_0000;
		if (paddr == CTRL_OFS) begin
			hit = 1'b1;
		end else if (paddr == STATE_OFS) begin
			hit = 1'b1;
			rd_word[NUM_LED-1:0] = held | comb_state;
			rd_word[STATE_COMB_LSB +: NUM_LED] = comb_state;
		end
		for (int i = 0; i < NUM_LED; i++) begin
			if (paddr == CFG_BASE_OFS + 12'(i) * CFG_STRIDE) begin
				hit = 1'b1;
				rd_word = cfg_a[i];
			end else if (paddr == CFG_BASE_OFS + 12'(i) * CFG_STRIDE + CFG_B_OFS) begin
				hit = 1'b1;
				rd_word = cfg_b[i];
			end
		end
	end

	assign pslverr = psel && penable && !hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_word;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_LED; g++) begin : g_led
			localparam logic [11:0] A_OFS = CFG_BASE_OFS + 12'(g) * CFG_STRIDE;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_a[g] <= CFGA_RST;
				end else if (wr_en && paddr == A_OFS) begin
					cfg_a[g] <= (cfg_a[g] & ~wmask) | (pwdata & wmask & 32'h3FFF_FFFF);
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_b[g] <= CFGB_RST;
				end else if (wr_en && paddr == A_OFS + CFG_B_OFS) begin
					cfg_b[g] <= (cfg_b[g] & ~wmask) | (pwdata & wmask & 32'h0000_773F);
				end
			end

			always_comb begin
				for (int k = 0; k < NUM_TRIG; k++) begin
					cfg[g].trig_sel[k] = cfg_a[g][k*SEL_W +: SEL_W];
				end
				cfg[g].trig_inv         = cfg_a[g][CFGA_INV_LSB +: NUM_TRIG];
				cfg[g].latch_en         = cfg_b[g][CFGB_LATCH_BIT];
				cfg[g].ack_sel          = cfg_b[g][CFGB_ACK_LSB +: SEL_W];
				cfg[g].on_state_colour  = cfg_b[g][CFGB_ON_LSB +: COL_W];
				cfg[g].off_state_colour = cfg_b[g][CFGB_OFF_LSB +: COL_W];
			end

			ledl_cell u_cell (
				.pclk              (pclk),
				.presetn           (presetn),
				.warm_restart      (warm_restart),
				.cfg               (cfg[g]),
				.status_pool       (status_pool),
				.global_hold_clear (global_hold_clear | sw_clear),
				.blink_phase       (blink_phase),
				.comb_state        (comb_state[g]),
				.held              (held[g]),
				.drive             (led_drive[g])
			);
		end
	endgenerate

	// ************************************************************
	// Software global clear and blink phase
	// ************************************************************
	// The software clear is a one-cycle pulse, so a hold that cannot release yet stays held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_clear <= 1'b0;
		end else begin
			sw_clear <= wr_en && paddr == CTRL_OFS && pstrb[0] && pwdata[CTRL_CLEAR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_phase <= 1'b0;
		end else if (warm_restart) begin
			blink_phase <= 1'b0;
		end else if (blink_en) begin
			blink_phase <= ~blink_phase;
		end
	end

	// ************************************************************
	// System health indicator
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_ok_green <= 1'b0;
		end else begin
			sys_ok_green <= sys_ok;
		end
	end

endmodule // ledl_top

// ### dv/ledl_properties.sv
`timescale 1ns/1ps
module ledl_properties (
	input wire logic                                   pclk,
	input wire logic                                   presetn,
	input wire logic                                   psel,
	input wire logic                                   penable,
	input wire logic                                   pwrite,
	input wire logic [31:0]                            prdata,
	input wire logic                                   pready,
	input wire logic                                   pslverr,
	input wire logic [ledl_pkg::POOL_W-1:0]            status_pool,
	input wire logic                                   global_hold_clear,
	input wire logic                                   blink_en,
	input wire logic                                   warm_restart,
	input wire logic                                   sys_ok,
	input wire logic                                   sys_ok_green,
	input wire ledl_pkg::ledl_drive_t [ledl_pkg::NUM_LED-1:0] led_drive
);
	import ledl_pkg::*;
	// ************************************************************
	// Checks
	// ************************************************************
	logic [NUM_LED-1:0] both;
	logic               quiet;
	always_comb begin
		for (int i = 0; i < NUM_LED; i++) begin
			both[i] = led_drive[i].green & led_drive[i].red;
		end
	end
	// Four settled cycles cover the longest path from a cause to a lane.
	assign quiet = !psel && !blink_en && !warm_restart && !global_hold_clear;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	health_set_a: assert property (sys_ok |=> sys_ok_green)
		else $error("health lamp missed a set");
	health_clear_a: assert property ($fell(sys_ok) |=> !sys_ok_green)
		else $error("health lamp missed a clear");
	lane_exclusive_a: assert property (both == '0)
		else $error("both lanes lit on one indicator");
	restart_dark_a: assert property (warm_restart |=> led_drive == '0)
		else $error("drive not cleared by restart");
	stable_idle_a: assert property ((quiet && $stable(status_pool)) [*4] |=> $stable(led_drive))
		else $error("indicator moved with nothing driving it");
	bus_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	err_data_a: assert property (pslverr && !pwrite |-> prdata == '0)
		else $error("refused read returned data");
endmodule // ledl_properties

bind ledl_top ledl_properties u_prop (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.status_pool(status_pool), .global_hold_clear(global_hold_clear), .blink_en(blink_en),
	.warm_restart(warm_restart), .sys_ok(sys_ok), .sys_ok_green(sys_ok_green),
	.led_drive(led_drive));

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import ledl_pkg::*;
	// ************************************************************
	// Stimulus and model
	// ************************************************************
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sys_ok = 0;
	logic global_hold_clear = 0, blink_en = 0, warm_restart = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, status_pool = '0, prdata, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, er, sys_ok_green;
	ledl_drive_t [NUM_LED-1:0] led_drive;
	int          sel [NUM_LED][NUM_TRIG];
	bit [4:0]    inv [NUM_LED];
	int          lat [NUM_LED], ack [NUM_LED], onc [NUM_LED], offc [NUM_LED], held [NUM_LED];
	int          ph, cyc, miscompares, num_checks;
	ledl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .status_pool(status_pool),
		.global_hold_clear(global_hold_clear), .blink_en(blink_en),
		.warm_restart(warm_restart), .sys_ok(sys_ok), .sys_ok_green(sys_ok_green),
		.led_drive(led_drive));
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cfg(input int i);
		logic [31:0] a;
		a = 32'(inv[i]) << CFGA_INV_LSB;
		for (int k = 0; k < NUM_TRIG; k++)
			a |= 32'(sel[i][k]) << (SEL_W * k);
		apb(1, 12'(CFG_BASE_OFS + CFG_STRIDE * i), a);
		apb(1, 12'(CFG_BASE_OFS + CFG_STRIDE * i + CFG_B_OFS), 32'(lat[i]
			| ack[i] << CFGB_ACK_LSB | onc[i] << CFGB_ON_LSB | offc[i] << CFGB_OFF_LSB));
	endtask
	task automatic pulse(input bit w);
		@(posedge pclk);
		if (w) warm_restart <= 1;
		else blink_en <= 1;
		@(posedge pclk);
		warm_restart <= 0;
		blink_en <= 0;
		ph = w ? 0 : !ph;
	endtask
	function automatic logic [1:0] col(input int c);
		case (c)
			1: col = 2'b10;
			2: col = 2'b01;
			3: col = {1'b0, ph[0]};
			4: col = {ph[0], 1'b0};
			default: col = 2'b00;
		endcase
	endfunction
	// The hold is modelled after settling, so a clear is seen only while it stays applied.
	task automatic look(input logic g);
		logic [31:0] st;
		logic c, az, sh;
		repeat (4) @(posedge pclk);
		st = '0;
		for (int i = 0; i < NUM_LED; i++) begin
			c = 0;
			az = 1;
			for (int k = 0; k < NUM_TRIG; k++)
				if (sel[i][k] != 0) begin
					c |= status_pool[sel[i][k]] ^ inv[i][k];
					az = 0;
				end
			if (lat[i] != 0 && c) held[i] = 1;
			else if (!c && (g || lat[i] == 0 || az || (ack[i] != 0 && status_pool[ack[i]])))
				held[i] = 0;
			sh = c | (held[i] != 0);
			chk(32'(led_drive[i]), 32'(col(sh ? onc[i] : offc[i])));
			st[i] = sh;
			st[STATE_COMB_LSB + i] = c;
		end
		apb(0, STATE_OFS, '0);
		chk(rd, st);
	endtask
	task automatic pl(input logic [31:0] p, input logic g);
		status_pool <= p;
		global_hold_clear <= g;
		sys_ok <= 1'($urandom);
		look(g);
	endtask
	initial begin
		int i;
		rd = $urandom(26233);
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'(CFG_BASE_OFS + CFG_STRIDE * 7), '0);
		chk(rd, CFGA_RST);
		apb(0, 12'(CFG_BASE_OFS + CFG_STRIDE * 7 + CFG_B_OFS), '0);
		chk(rd, CFGB_RST);
		apb(0, 12'hff0, '0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		for (int n = 0; n < 16; n++) begin
			i = $urandom % NUM_LED;
			for (int k = 0; k < NUM_TRIG; k++)
				sel[i][k] = $urandom % POOL_W;
			if (n % 4 == 0) sel[i][4] = 0;
			inv[i] = 5'($urandom);
			onc[i] = n % 8;
			offc[i] = (n + 3) % 8;
			cfg(i);
			if (n % 2) pulse(0);
			pl($urandom, 0);
		end
		pl(0, 0);
		sel[0] = '{5, 0, 0, 0, 0};
		inv[0] = 0;
		lat[0] = 1;
		ack[0] = 6;
		onc[0] = 2;
		offc[0] = 1;
		cfg(0);
		pl(32, 0);
		pl(0, 0);
		pl(96, 0);
		pl(32, 0);
		pulse(1);
		look(0);
		pl(0, 0);
		pl(64, 0);
		pl(32, 0);
		pl(0, 1);
		pl(32, 0);
		pl(0, 0);
		apb(1, CTRL_OFS, 32'h0000_0001);
		look(1);
		pl(32, 0);
		sel[0][0] = 0;
		cfg(0);
		pl(0, 0);
		sel[0][0] = 5;
		cfg(0);
		pl(32, 0);
		pl(0, 0);
		lat[0] = 0;
		cfg(0);
		look(0);
		close_out();
	end
endmodule // testbench
